// file: rtl/sesp_core.sv
// Serial EEPROM instruction handler: latch, status, protection and array read
`timescale 1ns/1ps
`default_nettype none
module sesp_core
  import sesp_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = SELF_TIMED_CYCLES,
  parameter int unsigned FIFO_DEPTH   = PAGE_BYTES
)(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic spi_cs_n,
  input  wire logic spi_sck,
  input  wire logic spi_mosi,
  input  wire logic wp_n,
  output logic      spi_miso,
  output logic      spi_miso_oe
);

  localparam int unsigned CNT_W  = $clog2(WRITE_CYCLES + 1);
  localparam int unsigned FIFO_W = OFF_W + 8;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and edge detection

  logic [3:0]     pins_s;
  logic           cs_n_s;
  logic           sck_s;
  logic           mosi_s;
  logic           wp_n_s;
  logic           sck_d_r;
  logic           cs_d_r;
  logic           sck_rise;
  logic           sck_fall;
  logic           cs_rise;
  logic           cs_fall;

  sesp_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pin_in   ({wp_n, spi_mosi, spi_sck, spi_cs_n}),
    .pin_sync (pins_s)
  );

  assign cs_n_s = pins_s[0];
  assign sck_s  = pins_s[1];
  assign mosi_s = pins_s[2];
  assign wp_n_s = pins_s[3];

  // Chip select history starts low so a fresh fall is needed after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r  <= cs_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d_r & ~cs_n_s;
  assign cs_rise  = cs_n_s & ~cs_d_r;
  assign cs_fall  = ~cs_n_s & cs_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // State and status registers

  sesp_state_type      state_r;
  sesp_state_type      state_nxt;
  sesp_state_type      op_state;
  logic [7:0]          shift_r;
  logic [2:0]          bit_cnt_r;
  logic [7:0]          op_r;
  logic                is_read_r;
  logic                addr_byte_r;
  logic [2:0]          addr_hi_r;
  logic [7:0]          rx_byte;
  logic                byte_done;
  logic                op_known;
  logic [ADDR_W-1:0]   addr_full;
  logic                write_enable_latch_r;
  logic                write_busy_flag_r;
  logic                block_guard_hi_r;
  logic                block_guard_lo_r;
  logic                status_lock_bit_r;
  logic                pin_guard_mode;
  logic                soft_guard_mode;
  logic [7:0]          status_byte;
  logic [2:0]          pend_r;
  logic                busy_kind_r;
  logic [CNT_W-1:0]    busy_cnt_r;
  logic                busy_end;
  logic                latch_set_ev;

  // Receiver, MSB first on rising edges
  // serial sampling edge
  assign rx_byte   = {shift_r[6:0], mosi_s};
  assign byte_done = sck_rise & (bit_cnt_r == 3'h7) & (state_r != ST_IDLE);
  assign addr_full = {addr_hi_r, rx_byte};

  assign status_byte = {status_lock_bit_r, 3'h0, block_guard_hi_r, block_guard_lo_r,
                        write_enable_latch_r, write_busy_flag_r};

  // guard mode from lock bit and pin
  // pin high or the lock bit clearing (reset, status write cycle end) ends it
  assign pin_guard_mode  = status_lock_bit_r & ~wp_n_s;
  assign soft_guard_mode = ~pin_guard_mode;

  assign op_known = (rx_byte == OPC_SET_LATCH) || (rx_byte == OPC_CLEAR_LATCH) ||
                    (rx_byte == OPC_STATUS_FETCH) || (rx_byte == OPC_STATUS_STORE) ||
                    (rx_byte == OPC_ARRAY_READ) || (rx_byte == OPC_ARRAY_WRITE);

  assign op_state =
    ((rx_byte == OPC_SET_LATCH) || (rx_byte == OPC_CLEAR_LATCH)) ? ST_WAIT :
    (rx_byte == OPC_STATUS_FETCH) ? ST_STAT :
    (rx_byte == OPC_STATUS_STORE) ? ST_SWDATA :
    (rx_byte == OPC_ARRAY_READ) ? (write_busy_flag_r ? ST_IGNORE : ST_ADDR) :
    ((rx_byte == OPC_ARRAY_WRITE) && write_enable_latch_r && !write_busy_flag_r) ? ST_ADDR :
    ST_IGNORE;

  // Next state
  // chip-select rise ends everything
  always_comb begin
    state_nxt = state_r;
    if (cs_rise) begin
      state_nxt = ST_IDLE;
    end else if (state_r == ST_IDLE) begin
      if (cs_fall) state_nxt = ST_OPCODE;
    end else if (byte_done) begin
      unique case (state_r)
        ST_OPCODE: state_nxt = op_state;
        ST_ADDR: begin
          if (addr_byte_r) state_nxt = is_read_r ? ST_RDATA : ST_WDATA;
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // Shift register, bit count, opcode and address bytes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shift_r     <= 8'h00;
      bit_cnt_r   <= 3'h0;
      op_r        <= 8'h00;
      is_read_r   <= 1'b0;
      addr_byte_r <= 1'b0;
      addr_hi_r   <= 3'h0;
    end else begin
      if (cs_fall) begin
        bit_cnt_r   <= 3'h0;
        addr_byte_r <= 1'b0;
      end else if (sck_rise) begin
        shift_r   <= rx_byte;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (byte_done && state_r == ST_OPCODE) begin
        op_r      <= rx_byte;
        is_read_r <= (rx_byte == OPC_ARRAY_READ);
      end
      if (byte_done && state_r == ST_ADDR && !addr_byte_r) begin
        addr_byte_r <= 1'b1;
        addr_hi_r   <= rx_byte[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status write capture and acceptance

  logic [7:0] sw_data_r;
  logic       sw_full_r;
  logic       sw_bad_r;
  logic       sw_accept;

  // Any rising clock edge after the data byte spoils the instruction
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sw_data_r <= 8'h00;
      sw_full_r <= 1'b0;
      sw_bad_r  <= 1'b0;
    end else if (cs_fall) begin
      sw_full_r <= 1'b0;
      sw_bad_r  <= 1'b0;
    end else if (sck_rise && state_r == ST_SWDATA) begin
      if (sw_full_r) sw_bad_r <= 1'b1;
      else if (bit_cnt_r == 3'h7) begin
        sw_data_r <= rx_byte;
        sw_full_r <= 1'b1;
      end
    end
  end

  assign sw_accept = cs_rise && (state_r == ST_SWDATA) && sw_full_r && !sw_bad_r &&
                     (bit_cnt_r == 3'h0) && write_enable_latch_r &&
                     !write_busy_flag_r && soft_guard_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Array write capture through the page buffer

  logic [PAGE_W-1:0] wr_page_r;
  logic [OFF_W-1:0]  wr_off_r;
  logic              wr_any_r;
  logic              wr_push;
  logic              wr_accept;
  logic              wr_guarded;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic              fifo_flush;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [7:0]        array [2**ADDR_W];

  assign wr_guarded =
    ({block_guard_hi_r, block_guard_lo_r} == GUARD_ALL) ||
    (({block_guard_hi_r, block_guard_lo_r} == GUARD_HALF) && wr_page_r[PAGE_W-1]) ||
    (({block_guard_hi_r, block_guard_lo_r} == GUARD_QUARTER) && (&wr_page_r[PAGE_W-1 -: 2]));

  assign wr_push    = byte_done && (state_r == ST_WDATA);
  assign wr_accept  = cs_rise && (state_r == ST_WDATA) && wr_any_r && (bit_cnt_r == 3'h0) &&
                      write_enable_latch_r && !write_busy_flag_r && !wr_guarded;
  assign fifo_flush = cs_rise && (state_r == ST_WDATA) && !wr_accept;
  assign fifo_out_ready = write_busy_flag_r & busy_kind_r;

  // Bytes past a full page are dropped: the buffer holds one page only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_page_r <= '0;
      wr_off_r  <= '0;
      wr_any_r  <= 1'b0;
    end else if (byte_done && state_r == ST_ADDR && addr_byte_r && !is_read_r) begin
      wr_page_r <= addr_full[ADDR_W-1:OFF_W];
      wr_off_r  <= addr_full[OFF_W-1:0];
      wr_any_r  <= 1'b0;
    end else if (wr_push && fifo_in_ready) begin
      wr_off_r <= wr_off_r + 1'b1;
      wr_any_r <= 1'b1;
    end
  end

  sesp_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (fifo_flush),
    .in_valid  (wr_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({wr_off_r, rx_byte}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Array drains one byte per clock inside the self-timed cycle
  always_ff @(posedge clk_sys) begin
    if (fifo_out_valid && fifo_out_ready) begin
      array[{wr_page_r, fifo_out_data[FIFO_W-1:8]}] <= fifo_out_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed cycle and status bits

  assign busy_end     = write_busy_flag_r && (busy_cnt_r == '0);
  assign latch_set_ev = cs_rise && (state_r == ST_WAIT) && (op_r == OPC_SET_LATCH);

  // cycle starts on accepted chip-select rise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      write_busy_flag_r <= 1'b0;
      busy_kind_r       <= 1'b0;
      busy_cnt_r        <= '0;
    end else if (sw_accept || wr_accept) begin
      write_busy_flag_r <= 1'b1;
      busy_kind_r       <= wr_accept;
      busy_cnt_r        <= CNT_W'(WRITE_CYCLES - 1);
    end else if (busy_end) begin
      write_busy_flag_r <= 1'b0;
    end else if (write_busy_flag_r) begin
      busy_cnt_r <= busy_cnt_r - 1'b1;
    end
  end

  // cleared by clear, cycle end, reset
  always_ff @(posedge clk_sys) begin
    if (rst) write_enable_latch_r <= LATCH_RESET;
    else if (latch_set_ev) write_enable_latch_r <= 1'b1; // Set wins over a cycle end
    else if (busy_end || (cs_rise && state_r == ST_WAIT)) write_enable_latch_r <= 1'b0;
  end

  // guard bits only from status write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_lock_bit_r <= LOCK_RESET;
      block_guard_hi_r  <= GUARD_RESET;
      block_guard_lo_r  <= GUARD_RESET;
      pend_r            <= 3'h0;
    end else begin
      if (sw_accept) begin
        pend_r <= {sw_data_r[BIT_LOCK], sw_data_r[BIT_GUARD_HI], sw_data_r[BIT_GUARD_LO]};
      end
      if (busy_end && !busy_kind_r) begin
        {status_lock_bit_r, block_guard_hi_r, block_guard_lo_r} <= pend_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output

  logic [7:0]        tx_r;
  logic [2:0]        out_cnt_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic              stat_load;
  logic              rd_load;
  logic              rd_step;
  logic              out_state;

  assign stat_load = byte_done && (state_r == ST_OPCODE) && (rx_byte == OPC_STATUS_FETCH);
  assign rd_load   = byte_done && (state_r == ST_ADDR) && addr_byte_r && is_read_r;
  assign out_state = (state_r == ST_STAT) || (state_r == ST_RDATA);
  assign rd_step   = sck_fall && (state_r == ST_RDATA) && (out_cnt_r == 3'h7);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_r      <= 8'h00;
      out_cnt_r <= 3'h0;
      rd_addr_r <= '0;
    end else if (stat_load) begin
      tx_r      <= status_byte;
      out_cnt_r <= 3'h0;
    end else if (rd_load) begin
      tx_r      <= array[addr_full];
      rd_addr_r <= addr_full;
      out_cnt_r <= 3'h0;
    end else if (sck_fall && out_state) begin
      out_cnt_r <= out_cnt_r + 3'h1;
      if (out_cnt_r != 3'h7) tx_r <= {tx_r[6:0], 1'b0};
      else if (state_r == ST_STAT) tx_r <= status_byte;
      else begin
        tx_r      <= array[rd_addr_r + 1'b1];
        rd_addr_r <= rd_addr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || cs_rise) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= out_state;
      if (sck_fall && out_state) spi_miso <= tx_r[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_deselect_end;
    @(posedge clk_sys) disable iff (rst) cs_rise |=> (state_r == ST_IDLE) ##1 !spi_miso_oe;
  endproperty
  a_deselect_end: assert property (p_deselect_end) else $error("select rise did not end");

  property p_bad_opcode;
    @(posedge clk_sys) disable iff (rst)
      (byte_done && state_r == ST_OPCODE && !op_known && !cs_rise) |=> state_r == ST_IGNORE;
  endproperty
  a_bad_opcode: assert property (p_bad_opcode) else $error("unknown opcode not ignored");

  property p_busy_len;
    @(posedge clk_sys) disable iff (rst) $rose(write_busy_flag_r) |-> write_busy_flag_r[*8];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy flag dropped early");

  property p_busy_latch;
    @(posedge clk_sys) disable iff (rst) $rose(write_busy_flag_r) |-> $past(write_enable_latch_r);
  endproperty
  a_busy_latch: assert property (p_busy_latch) else $error("write began without latch");

  property p_guard_refuse;
    @(posedge clk_sys) disable iff (rst)
      ($rose(write_busy_flag_r) && !busy_kind_r) |-> !$past(pin_guard_mode);
  endproperty
  a_guard_refuse: assert property (p_guard_refuse) else $error("status write in guard mode");

  property p_latch_clear;
    @(posedge clk_sys) disable iff (rst)
      $fell(write_busy_flag_r) |-> !write_enable_latch_r || $past(latch_set_ev);
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch kept after cycle");

  property p_guard_apply;
    @(posedge clk_sys) disable iff (rst)
      $changed({status_lock_bit_r, block_guard_hi_r, block_guard_lo_r}) |->
        $fell(write_busy_flag_r) && !busy_kind_r;
  endproperty
  a_guard_apply: assert property (p_guard_apply) else $error("guard bits changed early");

  property p_latch_set;
    @(posedge clk_sys) disable iff (rst) $rose(write_enable_latch_r) |-> $past(latch_set_ev);
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch set by other means");

  property p_read_idle;
    @(posedge clk_sys) disable iff (rst) rd_load |-> !write_busy_flag_r;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read started while busy");

  property p_addr_wrap;
    @(posedge clk_sys) disable iff (rst) rd_step |=> rd_addr_r == $past(rd_addr_r) + 11'h001;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("read address step wrong");

endmodule
`default_nettype wire

// file: rtl/sesp_fifo.sv
// Page data buffer between the serial receiver and the array writer
`timescale 1ns/1ps
`default_nettype none
module sesp_fifo #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 32
)(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W:0]   wr_ptr_r;
  logic [PTR_W:0]   rd_ptr_r;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr_r[PTR_W] == rd_ptr_r[PTR_W]) ||
                     (wr_ptr_r[PTR_W-1:0] != rd_ptr_r[PTR_W-1:0]);
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = store[rd_ptr_r[PTR_W-1:0]];

  // Pointers
  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // Storage has no reset
  always_ff @(posedge clk_sys) begin
    if (push) store[wr_ptr_r[PTR_W-1:0]] <= in_data;
  end

endmodule
`default_nettype wire

// file: rtl/sesp_pkg.sv
// Shared constants and types for the serial EEPROM instruction handler
package sesp_pkg;

  // Array geometry: 2 Kbyte array, 32-byte pages
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned PAGE_W      = 6;
  localparam int unsigned OFF_W       = 5;
  localparam int unsigned PAGE_BYTES  = 32;

  // Instruction codes
  localparam logic [7:0] OPC_SET_LATCH    = 8'h06;
  localparam logic [7:0] OPC_CLEAR_LATCH  = 8'h04;
  localparam logic [7:0] OPC_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OPC_STATUS_STORE = 8'h01;
  localparam logic [7:0] OPC_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OPC_ARRAY_WRITE  = 8'h02;

  // Status byte field positions
  localparam int unsigned BIT_BUSY     = 0;
  localparam int unsigned BIT_LATCH    = 1;
  localparam int unsigned BIT_GUARD_LO = 2;
  localparam int unsigned BIT_GUARD_HI = 3;
  localparam int unsigned BIT_LOCK     = 7;

  // Values after reset of the guard bits and the write latch
  localparam logic       GUARD_RESET = 1'b0;
  localparam logic       LOCK_RESET  = 1'b0;
  localparam logic       LATCH_RESET = 1'b0;

  // Block guard codes
  localparam logic [1:0] GUARD_NONE    = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF    = 2'h2;
  localparam logic [1:0] GUARD_ALL     = 2'h3;

  // Self-timed cycle, value in ns and count at the 10 ns system clock
  localparam int unsigned CLK_PERIOD_NS                 = 10;
  localparam int unsigned SELF_TIMED_CYCLE_TIME_NS      = 1000000;
  localparam int unsigned SELF_TIMED_CYCLES             =
    SELF_TIMED_CYCLE_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPCODE, ST_WAIT, ST_STAT, ST_SWDATA, ST_ADDR, ST_RDATA, ST_WDATA, ST_IGNORE
  } sesp_state_type;

endpackage

// file: rtl/sesp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sesp_sync #(
  parameter int unsigned WIDTH = 4
)(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r   <= '0;
      pin_sync <= '0;
    end else begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule
`default_nettype wire

// file: verif/sesp_host.sv
// SPI host model for the serial EEPROM instruction handler
`timescale 1ns/1ps
`default_nettype none
module sesp_host (
  input  wire logic clk_sys,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe,
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_mosi
);
  logic rx_line;
  // Host input has a pull-up, so a released line reads high
  assign rx_line = spi_miso_oe ? spi_miso : 1'b1;
  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b1;
    spi_mosi = 1'b0;
  end
  // Mode 3, MSB first
  // Drive on the fall, read just before the next fall, 80 ns per bit
  task automatic bit_x(input logic b, output logic r);
    spi_sck  <= 1'b0;
    spi_mosi <= b;
    repeat (4) @(posedge clk_sys);
    spi_sck <= 1'b1;
    repeat (4) @(posedge clk_sys);
    r = rx_line;
  endtask
  // Select, then give the synchroniser time before the first clock edge
  task automatic sel();
    spi_cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // Select raised after last rise
  // Clock stands high between frames; data line flips so no stale value
  task automatic desel();
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: verif/test_sesp_core.sv
// Self-checking bench for the serial EEPROM instruction handler
`timescale 1ns/1ps
`default_nettype none
module test_sesp_core;
  import sesp_pkg::*;
  // Long enough that a status frame still sees the busy cycle
  localparam int unsigned WC = 2000;
  logic       clk_sys = 1'b0;
  logic       rst, wp_n, cs_n, sck, mosi, miso, oe;
  logic [7:0] rxq[$];
  int         mismatches = 0;
  int         num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  sesp_core #(.WRITE_CYCLES(WC)) sesp_core_i (
    .clk_sys(clk_sys), .rst(rst), .spi_cs_n(cs_n), .spi_sck(sck),
    .spi_mosi(mosi), .wp_n(wp_n), .spi_miso(miso), .spi_miso_oe(oe));
  sesp_host sesp_host_i (
    .clk_sys(clk_sys), .spi_miso(miso), .spi_miso_oe(oe),
    .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Whole frame of bytes, optional trailing bits, received bytes kept
  task automatic frame(input logic [7:0] q[$], input int extra = 0);
    logic [7:0] r;
    rxq = {};
    @(posedge clk_sys);
    sesp_host_i.sel();
    foreach (q[k]) begin
      for (int i = 7; i >= 0; i--) sesp_host_i.bit_x(q[k][i], r[i]);
      rxq.push_back(r);
    end
    for (int i = 0; i < extra; i++) sesp_host_i.bit_x(1'b1, r[0]);
    sesp_host_i.desel();
  endtask
  // Status read with one repeat in one frame
  task automatic st(input logic [7:0] e);
    frame('{8'h05, 8'h00, 8'h00});
    chk("status", rxq[1], e);
    chk("status repeat", rxq[2], e);
  endtask
  task automatic set_latch_cmd();
    frame('{8'h06});
  endtask
  // poll busy flag
  // Polling rather than sleeping keeps the next instruction out of the cycle
  task automatic wwait();
    logic [7:0] s;
    s = 8'h01;
    for (int n = 0; n < 40 && s[0] !== 1'b0; n++) begin
      frame('{8'h05, 8'h00});
      s = rxq[1];
    end
    chk("busy poll", s & 8'h01, 8'h00);
  endtask
  // Watchdog well beyond the expected run of some 200 us
  initial begin
    #500us;
    mismatches++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    st(8'h00);
    frame('{8'h01, 8'h8c});
    st(8'h00);
    set_latch_cmd();
    st(8'h02);
    frame('{8'h04});
    st(8'h00);
    $display("test latch done");
    set_latch_cmd();
    frame('{8'h01, 8'hff});
    frame('{8'h03, 8'h00, 8'h00, 8'h00});
    chk("read while busy", rxq[3], 8'hff);
    st(8'h03);
    wwait();
    st(8'h8c);
    wp_n <= 1'b0;
    set_latch_cmd();
    frame('{8'h01, 8'h00});
    st(8'h8e);
    frame('{8'h02, 8'h00, 8'h00, 8'h99});
    wp_n <= 1'b1;
    frame('{8'h01, 8'h00});
    st(8'h8f);
    wwait();
    st(8'h00);
    set_latch_cmd();
    frame('{8'h01, 8'h8c}, 1);
    st(8'h02);
    $display("test status write done");
    frame('{8'h02, 8'hff, 8'hfe, 8'ha5, 8'h5a});
    wwait();
    set_latch_cmd();
    frame('{8'h02, 8'h00, 8'h00, 8'h3c});
    wwait();
    st(8'h00);
    frame('{8'h02, 8'h00, 8'h00, 8'h77});
    frame('{8'h03, 8'hf7, 8'hfe, 8'h00, 8'h00, 8'h00});
    chk("read 7fe", rxq[3], 8'ha5);
    chk("read 7ff", rxq[4], 8'h5a);
    chk("read 000", rxq[5], 8'h3c);
    frame('{8'h03, 8'h00, 8'h00}, 3);
    st(8'h00);
    $display("test array done");
    wp_n <= 1'b0;
    set_latch_cmd();
    frame('{8'h01, 8'h04});
    wwait();
    set_latch_cmd();
    frame('{8'h02, 8'h06, 8'h00, 8'h11});
    st(8'h06);
    frame('{8'h02, 8'h05, 8'hff, 8'h22});
    wwait();
    frame('{8'h03, 8'h05, 8'hff, 8'h00});
    chk("read 5ff", rxq[3], 8'h22);
    frame('{8'hff, 8'h05, 8'h00});
    chk("unknown opcode", rxq[2], 8'hff);
    $display("test guard done");
    set_latch_cmd();
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    st(8'h00);
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
